// >>> rtl/pcc_top.v
// pwm cycle configuration register with value steering and overflow flag
`timescale 1ns/100ps
`include "pcc_defines.vh"
module pcc_top #(
    parameter NUM_MODULES = 6
) (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire [7:0] sfr_addr_i,
    input wire [7:0] sfr_page_i,
    input wire sfr_wr_i,
    input wire sfr_rd_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire [15:0] main_array_counter_i,
    input wire [NUM_MODULES-1:0] pwm_enable_i,
    input wire [NUM_MODULES-1:0] wide_pwm_select_i,
    output wire [16*NUM_MODULES-1:0] module_compare_value_o,
    output reg [3*NUM_MODULES-1:0] module_mode_o,
    output reg reload_select_o,
    output reg [1:0] cycle_length_select_o,
    output reg cycle_overflow_flag_o,
    output reg cycle_overflow_irq_o
);
    reg [7:0] cfg_q;
    reg [7:0] cfg_d;
    reg [7:0] rdata_d;
    reg [7:0] mod_rd_or;
    reg [15:0] cmp_q [0:NUM_MODULES-1];
    reg [15:0] arl_q [0:NUM_MODULES-1];
    wire cfg_hit;
    wire cycle_ovf;
    wire [7:0] mod_rd [0:NUM_MODULES-1];
    wire [3*NUM_MODULES-1:0] mode_d;
    integer k;

    assign cfg_hit = (sfr_addr_i == `PCC_CFG_ADDR) && (sfr_page_i == `PCC_CFG_PAGE);

    pcc_ovf_detect u_ovf (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .counter_i(main_array_counter_i),
        .clsel_i(cfg_q[`PCC_CLSEL_MSB:`PCC_CLSEL_LSB]),
        .cycle_ovf_o(cycle_ovf)
    );

    // configuration register next value
    always @* begin
        cfg_d = cfg_q;
        if (sfr_wr_i && cfg_hit) begin
            // unused bits masked out so they stay zero
            cfg_d = sfr_wdata_i & `PCC_CFG_WMASK;
        end
        // hardware set beats a software clear in the same cycle
        if (cycle_ovf) begin
            cfg_d[`PCC_OVF_FLAG_BIT] = 1'b1;
        end
    end

    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            cfg_q <= `PCC_CFG_RESET;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // per module value storage, steering and mode decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi = gi + 1) begin : g_mod
            wire [7:0] lo_addr;
            wire [7:0] hi_addr;
            wire page_ok;
            wire lo_hit;
            wire hi_hit;
            wire use_reload;
            wire [1:0] clsel;
            wire [15:0] sel_val;
            // sums kept wide, then cut to the 8-bit address on purpose
            localparam [31:0] LO_SUM = `PCC_MOD_LOW_BASE + (gi * 2);
            localparam [31:0] HI_SUM = LO_SUM + 1;

            assign lo_addr = LO_SUM[7:0];
            assign hi_addr = HI_SUM[7:0];
            assign page_ok = (sfr_page_i == `PCC_MOD_PAGE);
            assign lo_hit = page_ok && (sfr_addr_i == lo_addr);
            assign hi_hit = page_ok && (sfr_addr_i == hi_addr);
            assign clsel = cfg_q[`PCC_CLSEL_MSB:`PCC_CLSEL_LSB];
            // reload only matters for 9, 10 and 11 bit cycles
            assign use_reload = pwm_enable_i[gi] && !wide_pwm_select_i[gi] &&
                                (clsel != `PCC_CLEN_8);
            assign sel_val = cfg_q[`PCC_RELOAD_SEL_BIT] ? arl_q[gi] : cmp_q[gi];
            assign mod_rd[gi] = lo_hit ? sel_val[7:0] : (hi_hit ? sel_val[15:8] : 8'h00);

            // mode: 16-bit, shared length, or not pwm
            assign mode_d[3*gi +: 3] = !pwm_enable_i[gi] ? `PCC_MODE_OFF :
                                       wide_pwm_select_i[gi] ? `PCC_MODE_16 :
                                       (`PCC_MODE_8 | {1'b0, clsel});

            assign module_compare_value_o[16*gi +: 16] = cmp_q[gi];

            always @(posedge ref_clk_i) begin
                if (!reset_n_i) begin
                    cmp_q[gi] <= `PCC_VALUE_RESET;
                    arl_q[gi] <= `PCC_VALUE_RESET;
                end else begin
                    // reload first so a software write in the same cycle wins
                    if (cycle_ovf && use_reload) begin
                        cmp_q[gi] <= arl_q[gi];
                    end
                    if (sfr_wr_i && (lo_hit || hi_hit)) begin
                        if (cfg_q[`PCC_RELOAD_SEL_BIT]) begin
                            if (lo_hit) begin
                                arl_q[gi][7:0] <= sfr_wdata_i;
                            end else begin
                                arl_q[gi][15:8] <= sfr_wdata_i;
                            end
                        end else begin
                            if (lo_hit) begin
                                cmp_q[gi][7:0] <= sfr_wdata_i;
                            end else begin
                                cmp_q[gi][15:8] <= sfr_wdata_i;
                            end
                        end
                    end
                end
            end
        end
    endgenerate

    // read mux, unmapped addresses read zero
    always @* begin
        mod_rd_or = 8'h00;
        for (k = 0; k < NUM_MODULES; k = k + 1) begin
            mod_rd_or = mod_rd_or | mod_rd[k];
        end
        if (cfg_hit) begin
            rdata_d = cfg_q & `PCC_CFG_WMASK;
        end else begin
            rdata_d = mod_rd_or;
        end
    end

    // all outputs registered; status mirrors lag the register by one cycle
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            sfr_rdata_o <= 8'h00;
            module_mode_o <= {NUM_MODULES{`PCC_MODE_OFF}};
            reload_select_o <= 1'b0;
            cycle_length_select_o <= `PCC_CLEN_8;
            cycle_overflow_flag_o <= 1'b0;
            cycle_overflow_irq_o <= 1'b0;
        end else begin
            if (sfr_rd_i) begin
                sfr_rdata_o <= rdata_d;
            end
            module_mode_o <= mode_d;
            reload_select_o <= cfg_q[`PCC_RELOAD_SEL_BIT];
            cycle_length_select_o <= cfg_q[`PCC_CLSEL_MSB:`PCC_CLSEL_LSB];
            cycle_overflow_flag_o <= cfg_q[`PCC_OVF_FLAG_BIT];
            cycle_overflow_irq_o <= cfg_q[`PCC_OVF_FLAG_BIT] & cfg_q[`PCC_OVF_IE_BIT];
        end
    end
endmodule

// >>> rtl/pcc_defines.vh
// constants for the pwm cycle configuration register block
`ifndef PCC_DEFINES_VH
`define PCC_DEFINES_VH

`define PCC_CFG_ADDR 8'hD9
`define PCC_CFG_PAGE 8'h0F
`define PCC_CFG_RESET 8'h00
`define PCC_CFG_WMASK 8'hE3
`define PCC_RELOAD_SEL_BIT 7
`define PCC_OVF_IE_BIT 6
`define PCC_OVF_FLAG_BIT 5
`define PCC_CLSEL_MSB 1
`define PCC_CLSEL_LSB 0

`define PCC_MOD_PAGE 8'h00
`define PCC_MOD_LOW_BASE 8'hE9
`define PCC_VALUE_RESET 16'h0000

`define PCC_CLEN_8 2'h0
`define PCC_CLEN_9 2'h1
`define PCC_CLEN_10 2'h2
`define PCC_CLEN_11 2'h3

`define PCC_MODE_8 3'h0
`define PCC_MODE_16 3'h4
`define PCC_MODE_OFF 3'h7

`define PCC_CNT_BIT_8 7
`define PCC_CNT_BIT_9 8
`define PCC_CNT_BIT_10 9
`define PCC_CNT_BIT_11 10

`endif

// >>> rtl/pcc_ovf_detect.v
// cycle overflow detector on the main counter
`timescale 1ns/100ps
`include "pcc_defines.vh"
module pcc_ovf_detect (
    input wire ref_clk_i,
    input wire reset_n_i,
    input wire [15:0] counter_i,
    input wire [1:0] clsel_i,
    output reg cycle_ovf_o
);
    reg [15:0] prev_q;
    reg top_prev;
    reg top_cur;

    // overflow into bit k shows as bit k-1 falling from 1 to 0
    always @* begin
        case (clsel_i)
            `PCC_CLEN_8: begin
                top_prev = prev_q[`PCC_CNT_BIT_8];
                top_cur = counter_i[`PCC_CNT_BIT_8];
            end
            `PCC_CLEN_9: begin
                top_prev = prev_q[`PCC_CNT_BIT_9];
                top_cur = counter_i[`PCC_CNT_BIT_9];
            end
            `PCC_CLEN_10: begin
                top_prev = prev_q[`PCC_CNT_BIT_10];
                top_cur = counter_i[`PCC_CNT_BIT_10];
            end
            default: begin
                top_prev = prev_q[`PCC_CNT_BIT_11];
                top_cur = counter_i[`PCC_CNT_BIT_11];
            end
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            prev_q <= 16'h0000;
            cycle_ovf_o <= 1'b0;
        end else begin
            prev_q <= counter_i;
            cycle_ovf_o <= top_prev & ~top_cur;
        end
    end
endmodule

// >>> rtl/HANDOVER_unused_guard.v
// no logic in this file

// >>> testbench/pcc_top_sva.sv
// assertions for the pwm cycle configuration block
`timescale 1ns/100ps
module pcc_top_sva (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_page_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [15:0] main_array_counter_i,
    input wire logic reload_select_o,
    input wire logic [1:0] cycle_length_select_o,
    input wire logic cycle_overflow_flag_o,
    input wire logic cycle_overflow_irq_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire cfg_hit = sfr_addr_i == 8'hD9 && sfr_page_i == 8'h0F;
    wire clr_req = sfr_wr_i && cfg_hit && !sfr_wdata_i[5];
    wire ovf_bit = main_array_counter_i[7 + cycle_length_select_o];
    logic bit_q;
    // watched bit one edge back, index lags the register by design
    always @(posedge ref_clk_i) begin
        bit_q <= ovf_bit;
    end
    a_cfg_to_out: assert property (
        sfr_wr_i && cfg_hit |-> ##2 reload_select_o == $past(sfr_wdata_i[7], 2)
        && cycle_length_select_o == $past(sfr_wdata_i[1:0], 2)) else $error("cfg outputs wrong");
    a_page_guard: assert property (
        sfr_wr_i && sfr_addr_i == 8'hD9 && sfr_page_i != 8'h0F |-> ##2 $stable(reload_select_o))
        else $error("cfg written on wrong page");
    a_irq_masked: assert property (cycle_overflow_irq_o |-> cycle_overflow_flag_o)
        else $error("irq without flag");
    a_flag_sticky: assert property ($fell(cycle_overflow_flag_o) |-> $past(clr_req, 2))
        else $error("flag cleared without software");
    a_ovf_sets: assert property (
        bit_q && !ovf_bit && $stable(cycle_length_select_o) && !$past(sfr_wr_i)
        |-> ##[2:4] cycle_overflow_flag_o) else $error("overflow not flagged");
    a_rdata_hold: assert property (!$past(sfr_rd_i) |-> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    a_unused_zero: assert property (sfr_rd_i && cfg_hit |=> sfr_rdata_o[4:2] == 3'h0)
        else $error("unused bits not zero");
    a_unmapped_read: assert property (sfr_rd_i && sfr_page_i == 8'h55 |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind pcc_top pcc_top_sva u_pcc_top_sva (.*);

// >>> testbench/pcc_top_bench.sv
// self-checking bench for the pwm cycle configuration block
`timescale 1ns/100ps
module pcc_top_bench;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic wr = 1'b0, rd = 1'b0, rd_seen = 1'b0;
    logic [7:0] addr = 8'h00, page = 8'h00, wdata = 8'h00, rdata, r, r2;
    logic [7:0] exp_q[$];
    logic [15:0] cnt = 16'h0000;
    logic [5:0] en = 6'h00, wide = 6'h00;
    logic [95:0] cv;
    logic [17:0] mode;
    logic [1:0] clsel;
    logic rsel, flag, irq, sel_m = 1'b0;
    logic rd_st = 1'b0, rd_cv = 1'b0, st_seen = 1'b0, cv_seen = 1'b0;
    logic [22:0] exp_st[$];
    logic [95:0] exp_cv[$];
    wire [22:0] st = {irq, flag, rsel, clsel, mode};
    int n_fail = 0, cmp_count = 0, cycles = 0;
    pcc_top #(.NUM_MODULES(6)) u_pcc_top (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .sfr_addr_i(addr), .sfr_page_i(page), .sfr_wr_i(wr), .sfr_rd_i(rd),
        .sfr_wdata_i(wdata), .sfr_rdata_o(rdata), .main_array_counter_i(cnt),
        .pwm_enable_i(en), .wide_pwm_select_i(wide), .module_compare_value_o(cv),
        .module_mode_o(mode), .reload_select_o(rsel), .cycle_length_select_o(clsel),
        .cycle_overflow_flag_o(flag), .cycle_overflow_irq_o(irq));
    always #12.5 ref_clk_i = ~ref_clk_i;
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] s);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_st(input string what, input logic [22:0] e, input logic [22:0] s);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cmp_cv(input string what, input logic [95:0] e, input logic [95:0] s);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    // one access per call; a read notes its expected byte for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p,
        input logic [7:0] d);
        logic [17:0] em;
        @(posedge ref_clk_i);
        addr <= a;
        page <= p;
        wdata <= d;
        wr <= w;
        rd <= !w;
        rd_st <= !w && a == 8'hD9 && p == 8'h0F;
        rd_cv <= !w && a == 8'hE9 && p == 8'h00 && !sel_m;
        if (!w) begin
            exp_q.push_back(d);
        end
        if (w && a == 8'hD9 && p == 8'h0F) begin
            sel_m = d[7];
        end
        // status copies lag the register, so they match it at read time
        if (!w && a == 8'hD9 && p == 8'h0F) begin
            for (int m = 0; m < 6; m++) begin
                em[3*m +: 3] = !en[m] ? 3'h7 : (wide[m] ? 3'h4 : {1'b0, d[1:0]});
            end
            exp_st.push_back({d[5] & d[6], d[5], d[7], d[1:0], em});
        end
        if (!w && a == 8'hE9 && p == 8'h00 && !sel_m) begin
            exp_cv.push_back({88'h0, d});
        end
        @(posedge ref_clk_i);
        wr <= 1'b0;
        rd <= 1'b0;
        rd_st <= 1'b0;
        rd_cv <= 1'b0;
    endtask
    // read data is registered, so it is judged one edge after the strobe
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        rd_seen <= rd;
        st_seen <= rd_st;
        cv_seen <= rd_cv;
        if (rd_seen && exp_q.size() > 0) begin
            cmp("read data", exp_q.pop_front(), rdata);
        end
        if (st_seen && exp_st.size() > 0) begin
            cmp_st("status", exp_st.pop_front(), st);
        end
        if (cv_seen && exp_cv.size() > 0) begin
            cmp_cv("compare value", exp_cv.pop_front(), cv);
        end
        if (cycles == 2000) begin
            n_fail++;
            end_sim();
        end
    end
    initial begin
        r = $urandom(26967);
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        acc(0, 8'hD9, 8'h0F, 8'h00);
        acc(1, 8'hD9, 8'h0F, 8'hFF);
        acc(0, 8'hD9, 8'h0F, 8'hE3);
        acc(1, 8'hD9, 8'h00, 8'h00);
        acc(0, 8'hD9, 8'h0F, 8'hE3);
        acc(0, 8'hD9, 8'h55, 8'h00);
        en <= 6'h01;
        wide <= 6'h01;
        acc(1, 8'hD9, 8'h0F, 8'h00);
        acc(0, 8'hD9, 8'h0F, 8'h00);
        wide <= 6'h00;
        for (int k = 0; k < 4; k++) begin
            r = $urandom;
            r2 = $urandom;
            acc(1, 8'hD9, 8'h0F, {6'h00, k[1:0]});
            acc(1, 8'hE9, 8'h00, r);
            acc(1, 8'hD9, 8'h0F, {6'h20, k[1:0]});
            acc(1, 8'hE9, 8'h00, r2);
            acc(0, 8'hE9, 8'h00, r2);
            acc(1, 8'hD9, 8'h0F, {1'b0, k[0], 4'h0, k[1:0]});
            acc(0, 8'hE9, 8'h00, r);
            cnt <= 16'hFFFF >> (8 - k);
            @(posedge ref_clk_i);
            cnt <= cnt + 16'h0001;
            repeat (6) @(posedge ref_clk_i);
            acc(0, 8'hD9, 8'h0F, {1'b0, k[0], 4'h8, k[1:0]});
            acc(0, 8'hE9, 8'h00, k == 0 ? r : r2);
            cnt <= 16'h0000;
        end
        end_sim();
    end
endmodule
